// *** rtl/adcs_pkg.sv ***
// Constants shared by the conversion sequencer and its helper modules.
// Assumes an 8-bit register port and a system clock of 10 MHz.
package adcs_pkg;
  localparam int ADCS_DATA_W = 8;
  localparam int ADCS_ADDR_W = 8;
  localparam int ADCS_CHAN_W = 3;
  localparam int ADCS_CNT_W = 6;

  localparam logic [ADCS_ADDR_W-1:0] ADCS_MODE_OFS = 8'hBC;
  localparam logic [ADCS_ADDR_W-1:0] ADCS_RESULT_OFS = 8'hBD;
  localparam logic [ADCS_ADDR_W-1:0] ADCS_START_OFS = 8'hBE;
  localparam logic [ADCS_ADDR_W-1:0] ADCS_PINSEL_OFS = 8'hEF;
  localparam logic [ADCS_ADDR_W-1:0] ADCS_IRQ_STAT_OFS = 8'hF0;
  localparam logic [ADCS_ADDR_W-1:0] ADCS_IRQ_EN_OFS = 8'hF1;

  localparam int ADCS_SPEED_BIT = 7;
  localparam int ADCS_START_BIT = 7;
  localparam int ADCS_DONE_BIT = 0;
  localparam int ADCS_IEN_BIT = 0;

  localparam logic [ADCS_DATA_W-1:0] ADCS_MODE_RESET = 8'h78;
  localparam logic [ADCS_DATA_W-1:0] ADCS_MODE_FILL = 8'h78;
  localparam logic [ADCS_DATA_W-1:0] ADCS_START_FILL = 8'h7F;
  localparam logic [ADCS_DATA_W-1:0] ADCS_PINSEL_RESET = 8'h00;

  // Conversion periods in system clock periods.
  localparam int ADCS_SLOW_PERIOD_CLK = 62;
  localparam int ADCS_FAST_PERIOD_CLK = 31;
  localparam int ADCS_SAR_BITS = 8;
  // Each period is one sample phase followed by eight equal bit trials.
  localparam int ADCS_FAST_STEP_CLK = 3;
  localparam int ADCS_SLOW_STEP_CLK = 2 * ADCS_FAST_STEP_CLK;
  localparam int ADCS_FAST_SAMPLE_CLK = ADCS_FAST_PERIOD_CLK - ADCS_SAR_BITS * ADCS_FAST_STEP_CLK;
  localparam int ADCS_SLOW_SAMPLE_CLK = ADCS_SLOW_PERIOD_CLK - ADCS_SAR_BITS * ADCS_SLOW_STEP_CLK;

  localparam logic [ADCS_CNT_W-1:0] ADCS_FAST_PERIOD_LD = ADCS_CNT_W'(ADCS_FAST_PERIOD_CLK - 1);
  localparam logic [ADCS_CNT_W-1:0] ADCS_SLOW_PERIOD_LD = ADCS_CNT_W'(ADCS_SLOW_PERIOD_CLK - 1);
  localparam logic [ADCS_CNT_W-1:0] ADCS_FAST_STEP_LD = ADCS_CNT_W'(ADCS_FAST_STEP_CLK - 1);
  localparam logic [ADCS_CNT_W-1:0] ADCS_SLOW_STEP_LD = ADCS_CNT_W'(ADCS_SLOW_STEP_CLK - 1);
  localparam logic [ADCS_CNT_W-1:0] ADCS_FAST_SAMPLE_LD = ADCS_CNT_W'(ADCS_FAST_SAMPLE_CLK - 1);
  localparam logic [ADCS_CNT_W-1:0] ADCS_SLOW_SAMPLE_LD = ADCS_CNT_W'(ADCS_SLOW_SAMPLE_CLK - 1);

  typedef enum logic [2:0] {
    ADCS_IDLE = 3'b001,
    ADCS_SAMPLE = 3'b010,
    ADCS_TRIAL = 3'b100
  } adcs_state_e;
endpackage : adcs_pkg

// *** rtl/adcs_down_counter.sv ***
// Loadable down counter with a zero flag.
// Assumes the caller pulses load and dec from logic on the same clock.
`timescale 1ns/10ps
module adcs_down_counter #(
  parameter int W = 6
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic dec,
  output logic [W-1:0] count,
  output logic zero
);
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      count <= '0;
    else if (clk_en && load)
      count <= load_val;
    else if (clk_en && dec && (count != '0))
      count <= count - W'(1);
  end

  assign zero = (count == '0);
endmodule : adcs_down_counter

// *** rtl/adcs_sar.sv ***
// Successive approximation register: one trial bit per decision, MSB first.
// Assumes keep is the comparator verdict for the code currently offered.
`timescale 1ns/10ps
module adcs_sar #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic init,
  input wire logic decide,
  input wire logic keep,
  output logic [W-1:0] code,
  output logic [W-1:0] trial,
  output logic [W-1:0] decided
);
  // The decided word is offered combinationally so the last bit can be
  // captured in the same cycle that the conversion period ends.
  assign decided = keep ? code : (code & ~trial);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      code <= '0;
      trial <= '0;
    end
    else if (clk_en && init)
    begin
      code <= {1'b1, {(W-1){1'b0}}};
      trial <= {1'b1, {(W-1){1'b0}}};
    end
    else if (clk_en && decide)
    begin
      code <= decided | (trial >> 1);
      trial <= trial >> 1;
    end
  end
endmodule : adcs_sar

// *** rtl/adcs_sequencer.sv ***
// Conversion sequencer for an eight-channel 8-bit successive approximation converter.
// Assumes a synchronous comparator input and a register master on the same clock.
`timescale 1ns/10ps
module adcs_sequencer
  import adcs_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [adcs_pkg::ADCS_ADDR_W-1:0] reg_addr,
  input wire logic [adcs_pkg::ADCS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [adcs_pkg::ADCS_DATA_W-1:0] reg_rdata,
  input wire logic cmp_keep,
  output logic [adcs_pkg::ADCS_DATA_W-1:0] dac_code,
  output logic sample_hold,
  output logic [adcs_pkg::ADCS_CHAN_W-1:0] chan_sel,
  output logic [adcs_pkg::ADCS_DATA_W-1:0] pin_analog_en,
  output logic irq
);
  import adcs_pkg::*;

  adcs_state_e state;
  logic conversion_start_flag;
  logic conversion_speed_select;
  logic fast_run;
  logic conversion_done_request;
  logic conversion_done_irq_enable;
  logic [ADCS_DATA_W-1:0] conversion_result_register;
  logic [ADCS_CNT_W-1:0] period_count;
  logic period_zero;
  logic [ADCS_CNT_W-1:0] step_count;
  logic step_zero;
  logic [ADCS_DATA_W-1:0] sar_trial;
  logic [ADCS_DATA_W-1:0] sar_decided;
  logic [ADCS_DATA_W-1:0] sar_code;
  logic wr_mode;
  logic wr_start;
  logic wr_pinsel;
  logic wr_stat;
  logic wr_en;
  logic rd_stat;
  logic start_req;
  logic stop_req;
  logic done_now;
  logic step_load;
  logic [ADCS_CNT_W-1:0] step_load_val;
  logic sar_decide;
  logic [ADCS_DATA_W-1:0] next_rdata;

  assign wr_mode = reg_wr && (reg_addr == ADCS_MODE_OFS);
  assign wr_start = reg_wr && (reg_addr == ADCS_START_OFS);
  assign wr_pinsel = reg_wr && (reg_addr == ADCS_PINSEL_OFS);
  assign wr_stat = reg_wr && (reg_addr == ADCS_IRQ_STAT_OFS);
  assign wr_en = reg_wr && (reg_addr == ADCS_IRQ_EN_OFS);
  assign rd_stat = reg_rd && (reg_addr == ADCS_IRQ_STAT_OFS);

  // A write of 1 while already converting is ignored so the period is not cut short.
  assign start_req = wr_start && reg_wdata[ADCS_START_BIT] && !conversion_start_flag;
  assign stop_req = wr_start && !reg_wdata[ADCS_START_BIT] && conversion_start_flag;
  assign done_now = (state == ADCS_TRIAL) && period_zero && !stop_req;

  assign sar_decide = (state == ADCS_TRIAL) && step_zero;
  assign step_load = start_req || ((state != ADCS_IDLE) && step_zero);
  always_comb
  begin
    if (start_req)
      step_load_val = conversion_speed_select ? ADCS_FAST_SAMPLE_LD : ADCS_SLOW_SAMPLE_LD;
    else
      step_load_val = fast_run ? ADCS_FAST_STEP_LD : ADCS_SLOW_STEP_LD;
  end

  adcs_down_counter #(
    .W(ADCS_CNT_W)
  ) u_period (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .load(start_req),
    .load_val(conversion_speed_select ? ADCS_FAST_PERIOD_LD : ADCS_SLOW_PERIOD_LD),
    .dec(state != ADCS_IDLE),
    .count(period_count),
    .zero(period_zero)
  );

  adcs_down_counter #(
    .W(ADCS_CNT_W)
  ) u_step (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .load(step_load),
    .load_val(step_load_val),
    .dec(state != ADCS_IDLE),
    .count(step_count),
    .zero(step_zero)
  );

  adcs_sar #(
    .W(ADCS_DATA_W)
  ) u_sar (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .init(start_req),
    .decide(sar_decide),
    .keep(cmp_keep),
    .code(sar_code),
    .trial(sar_trial),
    .decided(sar_decided)
  );

  assign dac_code = sar_code;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state <= ADCS_IDLE;
    else if (clk_en)
    begin
      unique case (state)
        ADCS_IDLE:
          if (start_req)
            state <= ADCS_SAMPLE;
        ADCS_SAMPLE:
          if (stop_req)
            state <= ADCS_IDLE;
          else if (step_zero)
            state <= ADCS_TRIAL;
        ADCS_TRIAL:
          if (stop_req || period_zero)
            state <= ADCS_IDLE;
        default:
          state <= ADCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      conversion_start_flag <= 1'b0;
    else if (clk_en)
    begin
      if (start_req)
        conversion_start_flag <= 1'b1;
      else if (stop_req || done_now)
        conversion_start_flag <= 1'b0;
    end
  end

  // Speed is frozen at start so a careless mode write cannot stretch a period.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      fast_run <= 1'b0;
    else if (clk_en && start_req)
      fast_run <= conversion_speed_select;
  end

  // No reset here: the last outcome survives a reset.
  always_ff @(posedge mclk)
  begin
    if (clk_en && done_now)
      conversion_result_register <= sar_decided;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      conversion_speed_select <= ADCS_MODE_RESET[ADCS_SPEED_BIT];
      chan_sel <= ADCS_MODE_RESET[ADCS_CHAN_W-1:0];
    end
    else if (clk_en && wr_mode)
    begin
      conversion_speed_select <= reg_wdata[ADCS_SPEED_BIT];
      chan_sel <= reg_wdata[ADCS_CHAN_W-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      pin_analog_en <= ADCS_PINSEL_RESET;
    else if (clk_en && wr_pinsel)
      pin_analog_en <= reg_wdata;
  end

  // A completion in the same cycle as a clearing read or write still sets the bit.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      conversion_done_request <= 1'b0;
    else if (clk_en)
    begin
      if (done_now)
        conversion_done_request <= 1'b1;
      else if (rd_stat || (wr_stat && !reg_wdata[ADCS_DONE_BIT]))
        conversion_done_request <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      conversion_done_irq_enable <= 1'b0;
    else if (clk_en && wr_en)
      conversion_done_irq_enable <= reg_wdata[ADCS_IEN_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else if (clk_en)
      irq <= conversion_done_request && conversion_done_irq_enable;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      sample_hold <= 1'b0;
    else if (clk_en)
      sample_hold <= start_req || ((state == ADCS_SAMPLE) && !step_zero && !stop_req);
  end

  always_comb
  begin
    next_rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADCS_MODE_OFS:
          next_rdata = ADCS_MODE_FILL
            | {conversion_speed_select, {(ADCS_DATA_W-1){1'b0}}}
            | {{(ADCS_DATA_W-ADCS_CHAN_W){1'b0}}, chan_sel};
        ADCS_RESULT_OFS:
          next_rdata = conversion_result_register;
        ADCS_START_OFS:
          next_rdata = ADCS_START_FILL | {conversion_start_flag, {(ADCS_DATA_W-1){1'b0}}};
        ADCS_IRQ_STAT_OFS:
          next_rdata = {{(ADCS_DATA_W-1){1'b0}}, conversion_done_request};
        ADCS_IRQ_EN_OFS:
          next_rdata = {{(ADCS_DATA_W-1){1'b0}}, conversion_done_irq_enable};
        default:
          next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (clk_en)
      reg_rdata <= next_rdata;
  end

  // Helper: cycles the flag has been high in the current conversion.
  logic [ADCS_CNT_W:0] run_cycles;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      run_cycles <= '0;
    else if (clk_en && start_req)
      run_cycles <= '0;
    else if (clk_en && conversion_start_flag)
      run_cycles <= run_cycles + (ADCS_CNT_W+1)'(1);
  end

  sequence seq_start;
    clk_en && start_req;
  endsequence

  sequence seq_done;
    clk_en && done_now;
  endsequence

  period_length_a: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_done |-> (run_cycles == (fast_run ? (ADCS_CNT_W+1)'(ADCS_FAST_PERIOD_CLK - 1)
      : (ADCS_CNT_W+1)'(ADCS_SLOW_PERIOD_CLK - 1))))
    else $error("conversion period length wrong");

  flag_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_start |=> conversion_start_flag && (state == ADCS_SAMPLE))
    else $error("start flag not set on start");

  done_request_a: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_done |=> conversion_done_request && !conversion_start_flag)
    else $error("done request not set at completion");

  irq_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(clk_en && !sys_rst) |->
      (irq == $past(conversion_done_request && conversion_done_irq_enable)))
    else $error("interrupt does not follow enabled request");

  result_transfer_a: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_done |=> (conversion_result_register == $past(sar_decided)) && (state == ADCS_IDLE))
    else $error("result not transferred at completion");

  restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_done ##[1:100] seq_start |=> conversion_start_flag ##1 (sar_code == 8'h80))
    else $error("restart after completion failed");

  stop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && stop_req && !rd_stat) |=> !conversion_start_flag && (state == ADCS_IDLE)
      && (conversion_done_request == $past(conversion_done_request)))
    else $error("stop did not end conversion");

  last_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_done |-> (sar_trial == 8'h01) && sar_decide)
    else $error("completion not on the last trial bit");

  channel_select_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && wr_mode) |=> (chan_sel == $past(reg_wdata[ADCS_CHAN_W-1:0])))
    else $error("channel field not taken from mode write");
endmodule : adcs_sequencer

// *** bench/test_adc_conversion_sequencer.sv ***
// Self-checking bench for the conversion sequencer: registers, timing, interrupt, results.
// Assumes the package and the sequencer top from rtl/ are compiled ahead of this file.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
  begin n_checks++; if ((gt) !== (ex)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module test_adc_conversion_sequencer;
  import adcs_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [ADCS_ADDR_W-1:0] reg_addr = '0;
  logic [ADCS_DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ADCS_DATA_W-1:0] reg_rdata;
  logic cmp_keep = 1'b0;
  logic [ADCS_DATA_W-1:0] dac_code;
  logic sample_hold;
  logic [ADCS_CHAN_W-1:0] chan_sel;
  logic [ADCS_DATA_W-1:0] pin_analog_en;
  logic irq;
  logic [7:0] ain = 8'h00;
  logic [7:0] last_res;
  int seed = 32'h135c;
  int cyc = 0;
  int bad_count = 0;
  int n_checks = 0;

  adcs_sequencer adcs_sequencer_inst (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_keep(cmp_keep), .dac_code(dac_code), .sample_hold(sample_hold),
    .chan_sel(chan_sel), .pin_analog_en(pin_analog_en), .irq(irq)
  );

  always #50 mclk = ~mclk;

  // Ideal comparator; its one-cycle lag is harmless since each trial lasts several cycles.
  always @(posedge mclk)
  begin
    cmp_keep <= (ain >= dac_code);
  end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc > 5000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Successive approximation against an ideal comparator, MSB first.
  function automatic logic [7:0] sar_ref(input logic [7:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 7; b >= 0; b--)
    begin
      c[b] = 1'b1;
      if (v < c)
        c[b] = 1'b0;
    end
    return c;
  endfunction : sar_ref

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata)
  endtask : chk_rd

  task automatic conv(input logic spd, input logic [2:0] ch, input logic en,
                      input logic [7:0] v);
    int t0;
    int per;
    per = spd ? ADCS_FAST_PERIOD_CLK : ADCS_SLOW_PERIOD_CLK;
    ain = v;
    wr(ADCS_MODE_OFS, {spd, 4'hF, ch});
    chk_rd("mode", ADCS_MODE_OFS, {spd, 4'hF, ch});
    `CHK("chan_sel", ch, chan_sel)
    wr(ADCS_PINSEL_OFS, 8'h01 << ch);
    `CHK("pin_analog_en", 8'h01 << ch, pin_analog_en)
    wr(ADCS_IRQ_EN_OFS, {7'h00, en});
    wr(ADCS_START_OFS, 8'h80);
    t0 = cyc;
    `CHK("sample_hold", 1'b1, sample_hold)
    `CHK("dac_code start", 8'h80, dac_code)
    chk_rd("start busy", ADCS_START_OFS, ADCS_START_FILL | 8'h80);
    while (cyc - t0 < per)
    begin
      @(posedge mclk);
      #1;
    end
    `CHK("irq early", 1'b0, irq)
    `CHK("sample_hold end", 1'b0, sample_hold)
    @(posedge mclk);
    #1;
    `CHK("irq", en, irq)
    chk_rd("start idle", ADCS_START_OFS, ADCS_START_FILL);
    chk_rd("result", ADCS_RESULT_OFS, sar_ref(v));
    `CHK("dac_code end", sar_ref(v), dac_code)
    if (!en)
    begin
      wr(ADCS_IRQ_EN_OFS, 8'h01);
      @(posedge mclk);
      #1;
      `CHK("irq unmasked", 1'b1, irq)
    end
    chk_rd("done set", ADCS_IRQ_STAT_OFS, 8'h01);
    chk_rd("done clear", ADCS_IRQ_STAT_OFS, 8'h00);
    `CHK("irq cleared", 1'b0, irq)
    last_res = v;
    $display("test conversion spd %0d chan %0d done", spd, ch);
  endtask : conv

  initial
  begin
    logic [31:0] r;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    chk_rd("mode reset", ADCS_MODE_OFS, ADCS_MODE_RESET);
    chk_rd("start reset", ADCS_START_OFS, ADCS_START_FILL);
    chk_rd("status reset", ADCS_IRQ_STAT_OFS, 8'h00);
    chk_rd("enable reset", ADCS_IRQ_EN_OFS, 8'h00);
    chk_rd("pinsel read", ADCS_PINSEL_OFS, 8'h00);
    `CHK("irq reset", 1'b0, irq)
    `CHK("pins reset", ADCS_PINSEL_RESET, pin_analog_en)
    $display("test reset done");
    conv(1'b1, 3'd1, 1'b1, 8'hFF);
    conv(1'b0, 3'd0, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      conv(r[8], 3'(i), r[9], r[7:0]);
    end
    // A stopped conversion must leave no result and no completion request.
    // The stop lands in the trial phase, after a second start write that must be ignored.
    wr(ADCS_MODE_OFS, 8'h03);
    ain = ~last_res;
    wr(ADCS_START_OFS, 8'h80);
    repeat (10) @(posedge mclk);
    wr(ADCS_START_OFS, 8'h80);
    chk_rd("start still busy", ADCS_START_OFS, ADCS_START_FILL | 8'h80);
    repeat (20) @(posedge mclk);
    wr(ADCS_START_OFS, 8'h00);
    chk_rd("start stopped", ADCS_START_OFS, ADCS_START_FILL);
    repeat (70) @(posedge mclk);
    chk_rd("no done", ADCS_IRQ_STAT_OFS, 8'h00);
    `CHK("irq stopped", 1'b0, irq)
    chk_rd("result kept", ADCS_RESULT_OFS, last_res);
    $display("test stop done");
    // Holding the clock enable low for 40 edges must delay completion by exactly 40 edges.
    ain = 8'h5A;
    wr(ADCS_MODE_OFS, 8'hFA);
    wr(ADCS_IRQ_EN_OFS, 8'h01);
    wr(ADCS_START_OFS, 8'h80);
    @(posedge mclk);
    clk_en <= 1'b0;
    repeat (40) @(posedge mclk);
    clk_en <= 1'b1;
    repeat (30) @(posedge mclk);
    #1;
    `CHK("irq frozen", 1'b0, irq)
    @(posedge mclk);
    #1;
    `CHK("irq after freeze", 1'b1, irq)
    chk_rd("frozen result", ADCS_RESULT_OFS, sar_ref(8'h5A));
    wr(ADCS_IRQ_STAT_OFS, 8'h00);
    chk_rd("done write clear", ADCS_IRQ_STAT_OFS, 8'h00);
    `CHK("irq write clear", 1'b0, irq)
    last_res = sar_ref(8'h5A);
    $display("test freeze done");
    wr(ADCS_RESULT_OFS, ~last_res);
    wr(8'h55, 8'hFF);
    chk_rd("unmapped", 8'h55, 8'h00);
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    chk_rd("result after reset", ADCS_RESULT_OFS, last_res);
    chk_rd("mode after reset", ADCS_MODE_OFS, ADCS_MODE_RESET);
    $display("test reset hold done");
    close_out();
  end
endmodule : test_adc_conversion_sequencer
